// *** core/bzc_exec.sv ***
// Execution of branch-on-zero and two-word subroutine call
// Sequencer overview
// The block sits between the fetch/decode stage and the program counter.
// One word is offered per cycle on instr, qualified by instr_valid.
// In the idle state a word is decoded and, for anything other than the
// branch or the first call word, the counter simply steps by one word.
//
// Branch on zero
// The zero flag is sampled with the branch word itself.
// When taken, the new counter is the already-stepped value plus twice
// the signed offset, and the following cycle is an empty slot.
// The word offered during that slot is dropped, since the fetch that
// produced it belonged to the old instruction stream.
// When not taken the branch costs a single cycle.
//
// Two-word call
// The first word carries the low target byte and the save option.
// Both are held until the second word arrives, which may be late:
// busy stays high for as long as the sequencer waits for it.
// The second word must carry the all-ones prefix; if it does not,
// the call is dropped, call_error pulses and the counter steps on.
// A good second word pushes the return address, loads the target
// and, with the save option set, copies the three registers to
// their shadows in that very cycle.
//
// Limitations
// Only the top of the return stack is held here; the stack itself,
// its pointer and overflow handling live outside this block.
// Interrupts and table reads are not seen by this sequencer.
// The status flags are inputs only; nothing here writes them.
`timescale 1ns/1ps
`default_nettype none
module bzc_exec
   import bzc_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic instr_valid,
   input wire logic [15:0] instr,
   input wire logic zero_flag,
   input wire logic [7:0] working_reg,
   input wire logic [7:0] status_reg,
   input wire logic [7:0] bank_select_reg,
   output logic [20:0] pc,
   output logic busy,
   output logic branch_on_zero_op,
   output logic push_strobe,
   output logic [20:0] return_stack_top,
   output logic call_error,
   output logic [7:0] working_shadow,
   output logic [7:0] status_shadow,
   output logic [7:0] bank_select_shadow
);
   bzc_state_t state, next_state;
   logic [20:0] pc_q, next_pc, tos_q, next_tos, inst_addr, next_inst_addr;
   logic [7:0] lo_k, next_lo_k;
   logic save_opt, next_save_opt;
   logic busy_q, next_busy, bz_q, next_bz, push_q, next_push;
   logic err_q, next_err;
   logic [7:0] w_q, st_q, bsr_q;

   bzc_sh_if sh ();

   // Sign-extend the offset and double it into a byte displacement
   function automatic logic [20:0] bzc_disp(input logic [7:0] n);
      bzc_disp = {{12{n[7]}}, n, 1'b0};
   endfunction : bzc_disp

   // Sequential step by one instruction word; used on several paths
   function automatic logic [20:0] bzc_seq(input logic [20:0] p);
      bzc_seq = p + BZC_PC_STEP;
   endfunction : bzc_seq

   // Next state of the sequencer; status flags are never written here
   always_comb begin
      next_state = state;
      next_pc = pc_q;
      next_tos = tos_q;
      next_inst_addr = inst_addr;
      next_lo_k = lo_k;
      next_save_opt = save_opt;
      next_busy = 1'b0;
      next_bz = 1'b0;
      next_push = 1'b0;
      next_err = 1'b0;
      sh.save = 1'b0;
      sh.w_in = working_reg;
      sh.status_in = status_reg;
      sh.bsr_in = bank_select_reg;
      unique case (state)
         BZC_EXEC: begin
            if (instr_valid) begin
               // PC still holds this word's address; the next PC points past it
               next_pc = bzc_seq(pc_q);
               next_inst_addr = pc_q;
               if (instr[15:8] == BZC_BZ_HI) begin
                  next_bz = 1'b1;
                  if (zero_flag) begin
                     next_pc = bzc_seq(pc_q)
                        + bzc_disp(instr[7:0]);
                     next_state = BZC_BR_NOP;
                     next_busy = 1'b1;
                  end
               end else if (instr[15:9] == BZC_CALL_HI) begin
                  next_lo_k = instr[7:0];
                  next_save_opt = instr[8];
                  next_state = BZC_CALL_W2;
                  next_busy = 1'b1;
               end
            end
         end
         BZC_BR_NOP: begin
            // Flushed fetch slot; nothing executes
            next_state = BZC_EXEC;
         end
         BZC_CALL_W2: begin
            if (instr_valid) begin
               next_state = BZC_EXEC;
               if (instr[15:12] == BZC_CALL2_HI) begin
                  next_tos = inst_addr + BZC_RET_STEP;
                  next_push = 1'b1;
                  next_pc = {instr[11:0], lo_k, 1'b0};
                  sh.save = save_opt;
               end else begin
                  // Malformed second word: abort, fall through
                  next_err = 1'b1;
                  next_pc = bzc_seq(pc_q);
               end
            end else begin
               next_busy = 1'b1; // Wait for second word
            end
         end
         default: begin
            // Unused state code: recover to idle rather than lock up
            next_state = BZC_EXEC;
         end
      endcase
   end

   // Register stage
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         state <= BZC_EXEC;
         pc_q <= BZC_PC_RST;
         tos_q <= BZC_PC_RST;
         inst_addr <= BZC_PC_RST;
         lo_k <= BZC_REG_RST;
         save_opt <= 1'b0;
         busy_q <= 1'b0;
         bz_q <= 1'b0;
         push_q <= 1'b0;
         err_q <= 1'b0;
      end else begin
         state <= next_state;
         pc_q <= next_pc;
         tos_q <= next_tos;
         inst_addr <= next_inst_addr;
         lo_k <= next_lo_k;
         save_opt <= next_save_opt;
         busy_q <= next_busy;
         bz_q <= next_bz;
         push_q <= next_push;
         err_q <= next_err;
      end
   end

   bzc_shadow u_shadow (
      .sys_clk(sys_clk),
      .rst(rst),
      .sh(sh)
   );

   // Shadow values are flop outputs in the bank
   always_comb begin
      w_q = sh.w_sh;
      st_q = sh.status_sh;
      bsr_q = sh.bsr_sh;
   end

   assign pc = pc_q;
   assign busy = busy_q;
   assign branch_on_zero_op = bz_q;
   assign push_strobe = push_q;
   assign return_stack_top = tos_q;
   assign call_error = err_q;
   assign working_shadow = w_q;
   assign status_shadow = st_q;
   assign bank_select_shadow = bsr_q;
endmodule : bzc_exec
`default_nettype wire

// *** core/bzc_shadow.sv ***
// Shadow copies of working, status and bank-select registers
`timescale 1ns/1ps
`default_nettype none
module bzc_shadow
   import bzc_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst,
   bzc_sh_if.bank sh
);
   logic [7:0] w_q, st_q, bsr_q;
   logic [7:0] next_w, next_st, next_bsr;

   // Copy all three only on a save request
   always_comb begin
      next_w = w_q;
      next_st = st_q;
      next_bsr = bsr_q;
      if (sh.save) begin
         next_w = sh.w_in;
         next_st = sh.status_in;
         next_bsr = sh.bsr_in;
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         w_q <= BZC_REG_RST;
         st_q <= BZC_REG_RST;
         bsr_q <= BZC_REG_RST;
      end else begin
         w_q <= next_w;
         st_q <= next_st;
         bsr_q <= next_bsr;
      end
   end

   assign sh.w_sh = w_q;
   assign sh.status_sh = st_q;
   assign sh.bsr_sh = bsr_q;
endmodule : bzc_shadow
`default_nettype wire

// *** shared/bzc_pkg.sv ***
// Package of constants and types for the branch and call execution block
package bzc_pkg;
   localparam int BZC_PC_W = 21;
   localparam int BZC_OP_W = 16;
   // Opcode patterns
   localparam logic [7:0] BZC_BZ_HI = 8'hE0;
   localparam logic [6:0] BZC_CALL_HI = 7'h76;
   localparam logic [3:0] BZC_CALL2_HI = 4'hF;
   // Program counter steps in bytes
   localparam logic [20:0] BZC_PC_STEP = 21'h000002;
   localparam logic [20:0] BZC_RET_STEP = 21'h000004;
   // Reset values
   localparam logic [20:0] BZC_PC_RST = 21'h000000;
   localparam logic [7:0] BZC_REG_RST = 8'h00;
   // Execution phases
   typedef enum logic [1:0] {
      BZC_EXEC,
      BZC_BR_NOP,
      BZC_CALL_W2
   } bzc_state_t;
endpackage : bzc_pkg

// *** shared/bzc_sh_if.sv ***
// Interface carrying shadow save request between the core and shadow bank
`timescale 1ns/1ps
`default_nettype none
interface bzc_sh_if;
   logic save;
   logic [7:0] w_in;
   logic [7:0] status_in;
   logic [7:0] bsr_in;
   logic [7:0] w_sh;
   logic [7:0] status_sh;
   logic [7:0] bsr_sh;
   modport ctrl (output save, w_in, status_in, bsr_in,
      input w_sh, status_sh, bsr_sh);
   modport bank (input save, w_in, status_in, bsr_in,
      output w_sh, status_sh, bsr_sh);
endinterface : bzc_sh_if
`default_nettype wire

// *** sim/bzc_exec_assertions.sv ***
// Checker of branch and call timing at the execution block's ports
`timescale 1ns/1ps
`default_nettype none
module bzc_exec_assertions
   import bzc_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic instr_valid,
   input wire logic zero_flag,
   input wire logic busy,
   input wire logic branch_on_zero_op,
   input wire logic push_strobe,
   input wire logic call_error,
   input wire logic [15:0] instr,
   input wire logic [7:0] working_reg,
   input wire logic [7:0] status_reg,
   input wire logic [7:0] bank_select_reg,
   input wire logic [7:0] working_shadow,
   input wire logic [7:0] status_shadow,
   input wire logic [7:0] bank_select_shadow,
   input wire logic [20:0] pc,
   input wire logic [20:0] return_stack_top
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);
   // Accepted words; busy marks the slot or a pending second word
   logic bz, c1;
   logic [23:0] regs, shad;
   assign bz = instr_valid && !busy && instr[15:8] == BZC_BZ_HI;
   assign c1 = instr_valid && !busy && instr[15:9] == BZC_CALL_HI;
   assign regs = {working_reg, status_reg, bank_select_reg};
   assign shad = {working_shadow, status_shadow, bank_select_shadow};
   sequence w2_s;
      c1 ##1 instr_valid && instr[15:12] == BZC_CALL2_HI;
   endsequence
   br_taken_a: assert property (
      bz && zero_flag |=> pc == $past(pc) + BZC_PC_STEP
      + {{12{$past(instr[7])}}, $past(instr[7:0]), 1'b0})
      else $error("branch target wrong");
   br_not_a: assert property (
      bz && !zero_flag |=> pc == $past(pc) + BZC_PC_STEP && !busy)
      else $error("untaken branch wrong");
   br_slot_a: assert property (
      bz && zero_flag |=> busy ##1 !busy && $stable(pc))
      else $error("branch slot wrong");
   br_pulse_a: assert property (
      bz |=> branch_on_zero_op) else $error("branch pulse missing");
   call_push_a: assert property (
      w2_s |=> push_strobe && return_stack_top == $past(pc, 2) + BZC_RET_STEP)
      else $error("return address wrong");
   call_tgt_a: assert property (
      w2_s |=> pc == {$past(instr[11:0]), $past(instr[7:0], 2), 1'b0})
      else $error("call target wrong");
   shadow_sv_a: assert property (
      w2_s |=> shad == ($past(instr[8], 2) ? $past(regs) : $past(shad)))
      else $error("shadow copy wrong");
   call_err_a: assert property (
      c1 ##1 instr_valid && instr[15:12] != BZC_CALL2_HI
      |=> call_error && !push_strobe) else $error("bad word accepted");
   // Main scenarios reached
   cov_tk_c: cover property (bz && zero_flag);
   cov_call_c: cover property (w2_s);
   cov_err_c: cover property (call_error);
endmodule : bzc_exec_assertions
bind bzc_exec bzc_exec_assertions u_chk (.*);
`default_nettype wire

// *** sim/tb_top.sv ***
// Self-checking bench for the branch and call execution block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import bzc_pkg::*;
   typedef struct {logic [15:0] w; logic z; logic [20:0] d;} bzc_row_t;
   logic sys_clk, rst, instr_valid, zero_flag, tk;
   logic busy, branch_on_zero_op, push_strobe, call_error;
   logic [15:0] instr;
   logic [7:0] working_reg, status_reg, bank_select_reg;
   logic [7:0] working_shadow, status_shadow, bank_select_shadow;
   logic [20:0] pc, return_stack_top, a;
   int n_fail, checked;
   // Offset extremes, untaken branch, unknown word
   bzc_row_t rows[5] = '{'{16'hE005, 1'b1, 21'h00000C},
      '{16'hE080, 1'b1, 21'h1FFF02}, '{16'hE07F, 1'b1, 21'h000100},
      '{16'hE0FF, 1'b0, 21'h000002}, '{16'h1234, 1'b1, 21'h000002}};
   bzc_exec u_dut (.*);
   // Clock, 40 ns period
   initial begin
      sys_clk = 0;
      forever #20 sys_clk = ~sys_clk;
   end
   task chk(input logic [20:0] s, input logic [20:0] e);
      checked++;
      if (s !== e) begin
         n_fail++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask : chk
   task issue(input logic [15:0] w, input logic v, input logic z);
      @(posedge sys_clk);
      instr <= w;
      instr_valid <= v;
      zero_flag <= z;
   endtask : issue
   task complete_run;
      $display("checked %0d n_fail %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : complete_run
   // Hang guard, far beyond the forty or so cycles used
   initial begin
      #20000;
      n_fail++;
      complete_run();
   end
   // Main sequence
   initial begin
      {rst, instr_valid, zero_flag, instr} = {1'b1, 18'h0};
      {working_reg, status_reg, bank_select_reg} = 24'hA53C0F;
      repeat (10) @(posedge sys_clk);
      rst <= 0;
      #1 chk({2'h0, busy, push_strobe, call_error, working_shadow, pc[7:0]}, 0);
      foreach (rows[i]) begin
         a = pc;
         tk = rows[i].w[15:8] === 8'hE0 && rows[i].z;
         issue(rows[i].w, 1, rows[i].z);
         issue(16'h0000, tk, 0); // Word offered in the slot is ignored
         #1 chk(pc, a + rows[i].d);
         chk(branch_on_zero_op, rows[i].w[15:8] === 8'hE0);
         chk(busy, tk);
         issue(16'h0000, 0, 0);
         #1 chk(busy, 0);
         chk(pc, a + rows[i].d);
      end
      for (int s = 1; s >= 0; s--) begin
         a = pc;
         issue({7'h76, s[0], 8'h34}, 1, 1);
         issue(16'hFABC, 1, 1);
         issue(16'h0000, 0, 0);
         #1 chk(pc, 21'h157868);
         chk(return_stack_top, a + 21'h4);
         chk(push_strobe, 1);
         @(posedge sys_clk);
         #1 chk(push_strobe, 0);
         chk({working_shadow, bank_select_shadow}, 16'hA50F);
         chk(status_shadow, 8'h3C);
         @(posedge sys_clk);
         working_reg <= 8'h5A;
         bank_select_reg <= 8'hF0;
      end
      issue(16'hEC00, 1, 0);
      issue(16'h1234, 1, 0);
      issue(16'h0000, 0, 0);
      #1 chk({call_error, push_strobe}, 2'h2);
      complete_run();
   end
endmodule : tb_top
`default_nettype wire
